// file: rtl/sbq_top.sv
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sbq_top #(
   parameter int ADDR_W = 9,
   parameter int DEPTH_LOG2 = sbq_pkg::DEPTH_LOG2
) (
   input wire logic CLK_SYS, // system clock
   input wire logic RST, // async reset, active high
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR, // write address
   input wire logic S_AXI_AWVALID, // write address valid
   output logic S_AXI_AWREADY, // write address ready
   input wire logic [sbq_pkg::DATA_W-1:0] S_AXI_WDATA, // write data
   input wire logic [3:0] S_AXI_WSTRB, // write strobes
   input wire logic S_AXI_WVALID, // write data valid
   output logic S_AXI_WREADY, // write data ready
   output logic [1:0] S_AXI_BRESP, // write response
   output logic S_AXI_BVALID, // write response valid
   input wire logic S_AXI_BREADY, // write response ready
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR, // read address
   input wire logic S_AXI_ARVALID, // read address valid
   output logic S_AXI_ARREADY, // read address ready
   output logic [sbq_pkg::DATA_W-1:0] S_AXI_RDATA, // read data
   output logic [1:0] S_AXI_RRESP, // read response
   output logic S_AXI_RVALID, // read data valid
   input wire logic S_AXI_RREADY, // read data ready
   input wire logic SAMPLE_VALID, // sensor word strobe
   input wire logic [sbq_pkg::WORD_W-1:0] SAMPLE_WORD, // sensor word, byte 0 low
   input wire logic [31:0] CLS_RESULT, // four classifier results, index 0 low
   input wire logic [31:0] TIMESTAMP, // free-running timestamp
   input wire logic FEAT_VALID, // filter or feature output strobe
   input wire logic [15:0] FEAT_VALUE, // half-float value
   input wire logic [15:0] FEAT_ID, // filter or feature identifier
   input wire logic TRIG_EVENT // routed motion event level
);
   import sbq_pkg::*;

   // ----
   // decode
   // ----
   function automatic logic [6:0] reg_idx(input logic [ADDR_W-1:0] a);
      reg_idx = a[8:2];
   endfunction

   function automatic sbq_state_t mode_state(input logic [2:0] m);
      case (m)
         MODE_BYPASS: mode_state = SBQ_ST_BYPASS;
         MODE_STOP_FULL: mode_state = SBQ_ST_STOP;
         MODE_CONT: mode_state = SBQ_ST_CONT;
         MODE_CONT_TO_STOP: mode_state = SBQ_ST_PRETRIG;
         default: mode_state = SBQ_ST_HOLD;
      endcase
   endfunction

   function automatic logic [1:0] low_pend(input logic [3:0] p);
      if (p[0])
         low_pend = 2'd0;
      else if (p[1])
         low_pend = 2'd1;
      else if (p[2])
         low_pend = 2'd2;
      else
         low_pend = 2'd3;
   endfunction

   // ----
   // state
   // ----
   sbq_state_t st_q;
   logic [2:0] mode_q;
   logic [7:0] thr_q;
   logic cap_q;
   logic [3:0] emb_q;
   logic [8:0] cnt_q;
   logic [DEPTH_LOG2-1:0] wr_ptr_q;
   logic [DEPTH_LOG2-1:0] rd_ptr_q;
   logic halted_q;
   logic ovr_q;
   logic ovr_sticky_q;
   logic trig_prev_q;
   logic [31:0] cls_prev_q;
   logic [3:0] res_pend_q;
   logic feat_pend_q;
   logic [31:0] feat_word_q;
   logic [MEM_W-1:0] mem_rdata;

   logic aw_got_q;
   logic w_got_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   logic core_on;
   logic [8:0] cap_lim;
   logic full;
   logic storing;
   logic wrap_mode;
   logic wr_want;
   logic do_wr;
   logic ovr_ev;
   logic ar_take;
   logic pop;
   logic st_read;
   logic wr_fire;
   logic [1:0] res_sel;
   logic [MEM_W-1:0] wr_word;
   logic [31:0] rd_val;
   logic rd_hit;
   logic [3:0] cls_chg;

   // ----
   // queue control
   // ----
   assign core_on = emb_q[EMB_CORE_EARLY] | emb_q[EMB_CORE_NORMAL];
   assign cap_lim = cap_q ? {1'b0, thr_q} : QUEUE_DEPTH;
   assign full = (cnt_q >= cap_lim);
   assign storing = (st_q == SBQ_ST_STOP) || (st_q == SBQ_ST_CONT) || (st_q == SBQ_ST_PRETRIG);
   assign wrap_mode = (st_q == SBQ_ST_CONT) || (st_q == SBQ_ST_PRETRIG);
   assign wr_want = SAMPLE_VALID | (|res_pend_q) | feat_pend_q;
   assign ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
   assign pop = ar_take && (reg_idx(S_AXI_ARADDR) == IDX_OUT_B5) && (cnt_q != 9'h000)
      && (st_q != SBQ_ST_BYPASS);
   assign st_read = ar_take && (reg_idx(S_AXI_ARADDR) == IDX_STAT_HIGH);
   // a halted queue stays frozen even when reads free slots
   assign do_wr = storing && wr_want && !halted_q && (!full || wrap_mode);
   assign ovr_ev = do_wr && full && !pop;
   assign res_sel = low_pend(res_pend_q);

   always_comb
   begin
      wr_word = '0;
      if (SAMPLE_VALID)
      begin
         wr_word = {TAG_SENSOR, SAMPLE_WORD};
      end
      else if (|res_pend_q)
      begin
         wr_word = {TAG_RESULT, TIMESTAMP, 6'h00, res_sel, CLS_RESULT[res_sel*8 +: 8]};
      end
      else
      begin
         wr_word = {TAG_FILTER, 16'h0000, feat_word_q};
      end
   end

   // mode state machine
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         st_q <= SBQ_ST_BYPASS;
      end
      else if (wr_fire && reg_idx(awaddr_q) == IDX_CTRL_FOUR && wstrb_q[0])
      begin
         st_q <= mode_state(wdata_q[2:0]);
      end
      else
      begin
         case (st_q)
            SBQ_ST_PRETRIG:
            begin
               if (TRIG_EVENT && !trig_prev_q)
               begin
                  st_q <= SBQ_ST_STOP;
               end
            end
            SBQ_ST_BYPASS, SBQ_ST_STOP, SBQ_ST_CONT, SBQ_ST_HOLD:
            begin
               st_q <= st_q;
            end
            default:
            begin
               st_q <= SBQ_ST_BYPASS;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         trig_prev_q <= 1'b0;
      end
      else
      begin
         trig_prev_q <= TRIG_EVENT;
      end
   end

   // pointers, count and halt
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         cnt_q <= 9'h000;
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         halted_q <= 1'b0;
      end
      else if (st_q == SBQ_ST_BYPASS)
      begin
         cnt_q <= 9'h000;
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         halted_q <= 1'b0;
      end
      else
      begin
         if (do_wr)
         begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop || ovr_ev)
         begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (do_wr && !ovr_ev && !pop)
         begin
            cnt_q <= cnt_q + 9'h001;
         end
         else if (pop && !do_wr)
         begin
            cnt_q <= cnt_q - 9'h001;
         end
         if (st_q == SBQ_ST_STOP && full)
         begin
            halted_q <= 1'b1;
         end
      end
   end

   // overwrite flags: the setting event wins over any clear
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         ovr_q <= 1'b0;
         ovr_sticky_q <= 1'b0;
      end
      else
      begin
         if (ovr_ev)
         begin
            ovr_q <= 1'b1;
         end
         else if (pop || st_q == SBQ_ST_BYPASS)
         begin
            ovr_q <= 1'b0;
         end
         if (ovr_ev)
         begin
            ovr_sticky_q <= 1'b1;
         end
         else if (st_read)
         begin
            ovr_sticky_q <= 1'b0;
         end
      end
   end

   // ----
   // learning-core sources
   // ----
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_res
         assign cls_chg[gi] = (CLS_RESULT[gi*8 +: 8] != cls_prev_q[gi*8 +: 8]);
         always_ff @(posedge CLK_SYS or posedge RST)
         begin
            if (RST)
            begin
               res_pend_q[gi] <= 1'b0;
            end
            else if (cls_chg[gi] && emb_q[EMB_RESULT_BATCH] && core_on)
            begin
               res_pend_q[gi] <= 1'b1;
            end
            else if (do_wr && !SAMPLE_VALID && res_sel == 2'(gi))
            begin
               res_pend_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         cls_prev_q <= 32'h0000_0000;
      end
      else
      begin
         cls_prev_q <= CLS_RESULT;
      end
   end

   // one strobe per axis or per window close; a new strobe replaces a waiting one
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         feat_pend_q <= 1'b0;
         feat_word_q <= 32'h0000_0000;
      end
      else if (FEAT_VALID && emb_q[EMB_FILTER_BATCH] && core_on)
      begin
         feat_pend_q <= 1'b1;
         feat_word_q <= {FEAT_ID, FEAT_VALUE};
      end
      else if (do_wr && !SAMPLE_VALID && res_pend_q == 4'h0)
      begin
         feat_pend_q <= 1'b0;
      end
   end

   sbq_mem #(
      .W(MEM_W),
      .AW(DEPTH_LOG2)
   ) u_mem (
      .clk(CLK_SYS),
      .we(do_wr),
      .waddr(wr_ptr_q),
      .wdata(wr_word),
      .raddr(rd_ptr_q),
      .rdata(mem_rdata)
   );

   // ----
   // register bus: write side
   // ----
   assign wr_fire = aw_got_q && w_got_q && !S_AXI_BVALID;

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         S_AXI_AWREADY <= 1'b1;
         S_AXI_WREADY <= 1'b1;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= RESP_OKAY;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_got_q <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_got_q <= 1'b1;
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            case (reg_idx(awaddr_q))
               IDX_EMB_EN, IDX_CTRL_ONE, IDX_CTRL_TWO, IDX_CTRL_FOUR:
                  S_AXI_BRESP <= RESP_OKAY;
               default:
                  S_AXI_BRESP <= RESP_SLVERR;
            endcase
         end
         if (S_AXI_BVALID && S_AXI_BREADY)
         begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         mode_q <= MODE_BYPASS;
         thr_q <= RST_THRESHOLD;
         cap_q <= 1'b0;
         emb_q <= 4'h0;
      end
      else if (wr_fire && wstrb_q[0])
      begin
         case (reg_idx(awaddr_q))
            IDX_EMB_EN: emb_q <= wdata_q[3:0];
            IDX_CTRL_ONE: thr_q <= wdata_q[7:0];
            IDX_CTRL_TWO: cap_q <= wdata_q[CTRL2_CAP];
            IDX_CTRL_FOUR: mode_q <= wdata_q[2:0];
            default: mode_q <= mode_q;
         endcase
      end
   end

   // ----
   // register bus: read side
   // ----
   always_comb
   begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      case (reg_idx(S_AXI_ARADDR))
         IDX_EMB_EN: rd_val[3:0] = emb_q;
         IDX_CTRL_ONE: rd_val[7:0] = thr_q;
         IDX_CTRL_TWO: rd_val[CTRL2_CAP] = cap_q;
         IDX_CTRL_FOUR: rd_val[2:0] = mode_q;
         IDX_STAT_LOW: rd_val[7:0] = cnt_q[7:0];
         IDX_STAT_HIGH:
         begin
            rd_val[STH_COUNT_TOP] = cnt_q[8];
            rd_val[STH_OVR_STICKY] = ovr_sticky_q;
            rd_val[STH_OVR] = ovr_q;
            rd_val[STH_FULL_SOON] = storing && ((cnt_q + 9'h001) >= cap_lim);
            rd_val[STH_THRESHOLD] = (cnt_q >= {1'b0, thr_q});
         end
         IDX_OUT_TAG: rd_val[2:0] = (cnt_q == 9'h000) ? TAG_EMPTY : mem_rdata[MEM_W-1 -: TAG_W];
         default:
         begin
            if (reg_idx(S_AXI_ARADDR) >= IDX_OUT_B0 && reg_idx(S_AXI_ARADDR) <= IDX_OUT_B5)
            begin
               if (cnt_q != 9'h000)
               begin
                  rd_val[7:0] = mem_rdata[(reg_idx(S_AXI_ARADDR) - IDX_OUT_B0)*8 +: 8];
               end
            end
            else
            begin
               rd_hit = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         S_AXI_ARREADY <= 1'b1;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= RESP_OKAY;
      end
      else if (ar_take)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rd_val;
         S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
      begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_ARREADY <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: rtl/sbq_pkg.sv
// Operation
// - mode 000 stores nothing, empties the queue, stays empty until another mode
// - mode 001 stores until full, then holds contents until mode changes; here the halt is kept until mode 000
// - 9-bit stored word count tracks fill; top bit shows full, no further stores
// - cap bit limits size to threshold; full-soon rises when next write reaches it
// - threshold flag rises when stored words reach the programmed threshold
// - mode 110 keeps storing, wraps and overwrites oldest; host stops via bypass
// - continuous modes raise full-soon when next write fills or overruns
// - overwrite flag and sticky overwrite flag rise when a word is overwritten
// - one sensor gives 256 words; full-soon rises after level 254
// - mode selector is 3 bits wide with four modes
// - mode 011 runs continuous, then stop-when-full after the trigger
// - trigger is a routed motion event; host enables and routes it
// - trigger is edge sensitive; first edge switches, held until bypass; here the next mode write replaces it
// - trigger when full stops at once; otherwise fill until full, then stop
// - core words stored only while either core enable bit is set
// - result batching writes a word when any classifier result changes
// - result word: value, index 0..3, 32-bit timestamp low byte first
// - filters and recursive features stored at core output rate, one per axis
// - windowed features stored once at each window close
// - filter word: half-float value, 16-bit identifier, two reserved bytes
// - host reads six output bytes at 79h..7Eh once per stored word
package sbq_pkg;
   localparam int DATA_W = 32;
   localparam int DEPTH_LOG2 = 8;
   localparam logic [8:0] QUEUE_DEPTH = 9'h100;
   localparam int WORD_W = 48;
   localparam int TAG_W = 3;
   localparam int MEM_W = 51;
   // register indices; byte address is four times the index
   localparam logic [6:0] IDX_EMB_EN = 7'h04;
   localparam logic [6:0] IDX_CTRL_ONE = 7'h07;
   localparam logic [6:0] IDX_CTRL_TWO = 7'h08;
   localparam logic [6:0] IDX_CTRL_FOUR = 7'h0A;
   localparam logic [6:0] IDX_STAT_LOW = 7'h1B;
   localparam logic [6:0] IDX_STAT_HIGH = 7'h1C;
   localparam logic [6:0] IDX_OUT_TAG = 7'h78;
   localparam logic [6:0] IDX_OUT_B0 = 7'h79;
   localparam logic [6:0] IDX_OUT_B5 = 7'h7E;
   // field positions
   localparam int EMB_CORE_EARLY = 0;
   localparam int EMB_CORE_NORMAL = 1;
   localparam int EMB_RESULT_BATCH = 2;
   localparam int EMB_FILTER_BATCH = 3;
   localparam int CTRL2_CAP = 7;
   localparam int STH_COUNT_TOP = 0;
   localparam int STH_OVR_STICKY = 3;
   localparam int STH_FULL_SOON = 5;
   localparam int STH_OVR = 6;
   localparam int STH_THRESHOLD = 7;
   // mode codes
   localparam logic [2:0] MODE_BYPASS = 3'h0;
   localparam logic [2:0] MODE_STOP_FULL = 3'h1;
   localparam logic [2:0] MODE_CONT_TO_STOP = 3'h3;
   localparam logic [2:0] MODE_CONT = 3'h6;
   // word tags
   localparam logic [2:0] TAG_EMPTY = 3'h0;
   localparam logic [2:0] TAG_SENSOR = 3'h1;
   localparam logic [2:0] TAG_RESULT = 3'h2;
   localparam logic [2:0] TAG_FILTER = 3'h3;
   // reset value and bus response codes
   localparam logic [7:0] RST_THRESHOLD = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [4:0] {
      SBQ_ST_BYPASS = 5'b00001,
      SBQ_ST_STOP = 5'b00010,
      SBQ_ST_CONT = 5'b00100,
      SBQ_ST_PRETRIG = 5'b01000,
      SBQ_ST_HOLD = 5'b10000
   } sbq_state_t;
endpackage

// file: rtl/sbq_mem.sv
`timescale 1ns/1ps
`default_nettype none
module sbq_mem #(
   parameter int W = 51,
   parameter int AW = 8
) (
   input wire logic clk, // clock
   input wire logic we, // write enable
   input wire logic [AW-1:0] waddr, // write address
   input wire logic [W-1:0] wdata, // write data
   input wire logic [AW-1:0] raddr, // read address
   output logic [W-1:0] rdata // registered read data
);
   logic [W-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   // read-first: a word written this edge shows one edge later
   always_ff @(posedge clk)
   begin
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// file: verification/sbq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sbq_monitor
   import sbq_pkg::*;
#(
   parameter int ADDR_W = 9
) (
   input wire logic CLK_SYS, // clock
   input wire logic RST, // reset
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR, // aw addr
   input wire logic S_AXI_AWVALID, // aw valid
   input wire logic S_AXI_AWREADY, // aw ready
   input wire logic [DATA_W-1:0] S_AXI_WDATA, // w data
   input wire logic S_AXI_WVALID, // w valid
   input wire logic S_AXI_WREADY, // w ready
   input wire logic S_AXI_BVALID, // b valid
   input wire logic S_AXI_BREADY, // b ready
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR, // ar addr
   input wire logic S_AXI_ARVALID, // ar valid
   input wire logic S_AXI_ARREADY, // ar ready
   input wire logic [DATA_W-1:0] S_AXI_RDATA, // r data
   input wire logic [1:0] S_AXI_RRESP, // r resp
   input wire logic S_AXI_RVALID, // r valid
   input wire logic S_AXI_RREADY // r ready
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   logic ar_take;
   logic [6:0] ar_idx;
   logic [2:0] mode_q;
   assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
   assign ar_idx = S_AXI_ARADDR[8:2];
   // ----
   // mode shadow
   // ----
   always_ff @(posedge CLK_SYS or posedge RST)
      if (RST)
         mode_q <= MODE_BYPASS;
      else if (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
         && S_AXI_AWADDR[8:2] == IDX_CTRL_FOUR)
         mode_q <= S_AXI_WDATA[2:0];
   sequence s_wr_take;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence s_wr_answer;
      !S_AXI_BVALID ##1 S_AXI_BVALID;
   endsequence
   a_write_answer: assert property (s_wr_take |=> s_wr_answer)
      else $error("late write answer");
   a_wr_refused: assert property (s_wr_take |=> (!S_AXI_AWREADY && !S_AXI_WREADY) [*2])
      else $error("write channel ready while busy");
   a_b_release: assert property (S_AXI_BVALID && S_AXI_BREADY |=>
      !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
      else $error("write channel not released");
   a_read_answer: assert property (ar_take |=> S_AXI_RVALID && !S_AXI_ARREADY)
      else $error("late read answer");
   a_r_release: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY)
      else $error("read channel not released");
   a_data_okay: assert property (ar_take && ar_idx >= IDX_OUT_TAG && ar_idx <= IDX_OUT_B5 |=>
      S_AXI_RRESP == RESP_OKAY)
      else $error("output data read refused");
   a_mode_readback: assert property (ar_take && ar_idx == IDX_CTRL_FOUR |=>
      S_AXI_RDATA == {29'h0, mode_q})
      else $error("mode field readback wrong");
   a_bypass_empty: assert property (ar_take && ar_idx == IDX_STAT_LOW && mode_q == MODE_BYPASS |=>
      S_AXI_RDATA == 32'h0)
      else $error("count not zero in bypass");
   a_bypass_tag: assert property (ar_take && ar_idx == IDX_OUT_TAG && mode_q == MODE_BYPASS |=>
      S_AXI_RDATA[2:0] == TAG_EMPTY)
      else $error("word not empty in bypass");
endmodule
bind sbq_top sbq_monitor #(.ADDR_W(ADDR_W)) mon_u (.*);
`default_nettype wire

// file: verification/sbq_host_bfm.sv
`timescale 1ns/1ps
`default_nettype none
module sbq_host_bfm (
   input wire logic clk, // clock
   output logic [8:0] awaddr, // aw addr
   output logic awvalid, // aw valid
   input wire logic awready, // aw ready
   output logic [31:0] wdata, // w data
   output logic [3:0] wstrb, // w strobes
   output logic wvalid, // w valid
   input wire logic wready, // w ready
   input wire logic [1:0] bresp, // b resp
   input wire logic bvalid, // b valid
   output logic bready, // b ready
   output logic [8:0] araddr, // ar addr
   output logic arvalid, // ar valid
   input wire logic arready, // ar ready
   input wire logic [31:0] rdata, // r data
   input wire logic [1:0] rresp, // r resp
   input wire logic rvalid, // r valid
   output logic rready // r ready
);
   logic hung;
   assign wstrb = 4'hF;
   initial
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready, hung} = '0;
   // ----
   // bus master
   // ----
   // released lines go to the inverse so a stale value can never pass for a fresh one
   task automatic wr(input logic [6:0] idx, input logic [31:0] v, output logic [1:0] resp);
      logic aw_p;
      logic w_p;
      logic b_p;
      int n;
      {aw_p, w_p, b_p} = 3'b111;
      n = 0;
      resp = 2'h3;
      @(posedge clk);
      awaddr <= {idx, 2'b00};
      wdata <= v;
      {awvalid, wvalid, bready} <= 3'b111;
      do
      begin
         @(posedge clk);
         n++;
         if (aw_p && awready)
         begin
            aw_p = 1'b0;
            awvalid <= 1'b0;
            awaddr <= ~awaddr;
         end
         if (w_p && wready)
         begin
            w_p = 1'b0;
            wvalid <= 1'b0;
            wdata <= ~wdata;
         end
         if (bvalid)
         begin
            b_p = 1'b0;
            resp = bresp;
            bready <= 1'b0;
         end
      end while (b_p && n < 64);
      if (b_p)
         hung = 1'b1;
   endtask
   task automatic rd(input logic [6:0] idx, output logic [31:0] v, output logic [1:0] resp);
      logic ar_p;
      logic r_p;
      int n;
      {ar_p, r_p} = 2'b11;
      n = 0;
      {v, resp} = '1;
      @(posedge clk);
      araddr <= {idx, 2'b00};
      {arvalid, rready} <= 2'b11;
      do
      begin
         @(posedge clk);
         n++;
         if (ar_p && arready)
         begin
            ar_p = 1'b0;
            arvalid <= 1'b0;
            araddr <= ~araddr;
         end
         if (rvalid)
         begin
            r_p = 1'b0;
            {v, resp} = {rdata, rresp};
            rready <= 1'b0;
         end
      end while (r_p && n < 64);
      if (r_p)
         hung = 1'b1;
   endtask
endmodule
`default_nettype wire

// file: verification/sensor_batch_queue_modes_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module sensor_batch_queue_modes_test;
   import sbq_pkg::*;
   logic clk_sys, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, sv, fv, trig;
   logic [8:0] awaddr, araddr;
   logic [31:0] wdata, rdata, cls, ts, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [47:0] sw;
   logic [15:0] fval, fid;
   logic [7:0] k, kb;
   int miscompares = 0;
   int n_checks = 0;
   sbq_top dut_u (.CLK_SYS(clk_sys), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .SAMPLE_VALID(sv), .SAMPLE_WORD(sw), .CLS_RESULT(cls), .TIMESTAMP(ts), .FEAT_VALID(fv),
      .FEAT_VALUE(fval), .FEAT_ID(fid), .TRIG_EVENT(trig));
   sbq_host_bfm host_u (.clk(clk_sys), .*);
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // ----------------
   // shared helpers
   // ----------------
   task automatic wr(input logic [6:0] idx, input logic [31:0] v);
      host_u.wr(idx, v, r);
   endtask
   task automatic rd_chk(input logic [6:0] idx, input logic [31:0] e);
      host_u.rd(idx, d, r);
      `CHK(d, e)
   endtask
   // reading the last byte pops the word, so all seven are always read
   task automatic chk_word(input logic [55:0] e);
      for (int j = 0; j < 7; j++)
         rd_chk(IDX_OUT_TAG + 7'(j), {24'h0, e[8*j +: 8]});
   endtask
   function automatic logic [55:0] sword(input logic [7:0] k0);
      return {40'h5F4F3F2F1F, k0, 5'h0, TAG_SENSOR};
   endfunction
   task automatic push(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         sv <= 1'b1;
         sw <= {40'h5F4F3F2F1F, k};
         k = k + 8'h01;
      end
      @(posedge clk_sys);
      sv <= 1'b0;
   endtask
   task automatic idle;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic give_verdict;
      if (host_u.hung)
         miscompares++;
      if (miscompares == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk_sys)
      if (host_u.hung)
         give_verdict();
   initial
   begin
      {sv, fv, trig, sw, cls, ts, fval, fid, k, kb} = '0;
      rst = 1'b1;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      rd_chk(IDX_EMB_EN, 32'h0);
      rd_chk(IDX_CTRL_ONE, 32'h0);
      rd_chk(IDX_CTRL_TWO, 32'h0);
      rd_chk(IDX_STAT_HIGH, 32'h80);
      rd_chk(IDX_OUT_TAG, {29'h0, TAG_EMPTY});
      host_u.rd(7'h30, d, r);
      `CHK({r, d}, {RESP_SLVERR, 32'h0})
      host_u.wr(7'h30, 32'hFF, r);
      `CHK(r, RESP_SLVERR)
      for (int m = 1; m < 8; m++)
      begin
         wr(IDX_CTRL_FOUR, {29'h1F, 3'(m)});
         rd_chk(IDX_CTRL_FOUR, {29'h0, 3'(m)});
         wr(IDX_CTRL_FOUR, 32'h0);
      end
      wr(IDX_CTRL_ONE, 32'hFFFF_FF10);
      rd_chk(IDX_CTRL_ONE, 32'h10);
      wr(IDX_CTRL_FOUR, {29'h0, MODE_STOP_FULL});
      push(15);
      rd_chk(IDX_STAT_HIGH, 32'h00);
      push(1);
      rd_chk(IDX_STAT_HIGH, 32'h80);
      push(238);
      rd_chk(IDX_STAT_LOW, 32'hFE);
      rd_chk(IDX_STAT_HIGH, 32'h80);
      push(1);
      rd_chk(IDX_STAT_HIGH, 32'hA0);
      push(5);
      rd_chk(IDX_STAT_LOW, 32'h00);
      host_u.rd(IDX_STAT_HIGH, d, r);
      `CHK(d & 32'h81, 32'h81)
      chk_word(sword(8'h00));
      push(2);
      rd_chk(IDX_STAT_LOW, 32'hFF);
      wr(IDX_CTRL_FOUR, 32'h0);
      push(3);
      rd_chk(IDX_STAT_LOW, 32'h0);
      wr(IDX_CTRL_ONE, 32'h04);
      wr(IDX_CTRL_TWO, 32'h80);
      wr(IDX_CTRL_FOUR, {29'h0, MODE_CONT});
      kb = k;
      push(3);
      rd_chk(IDX_STAT_HIGH, 32'h20);
      push(1);
      rd_chk(IDX_STAT_HIGH, 32'hA0);
      trig <= 1'b1;
      idle();
      push(2);
      rd_chk(IDX_STAT_HIGH, 32'hE8);
      rd_chk(IDX_STAT_LOW, 32'h04);
      chk_word(sword(kb + 8'h02));
      rd_chk(IDX_STAT_HIGH, 32'h20);
      trig <= 1'b0;
      wr(IDX_CTRL_FOUR, 32'h0);
      wr(IDX_CTRL_FOUR, {29'h0, MODE_CONT_TO_STOP});
      kb = k;
      push(6);
      trig <= 1'b1;
      idle();
      push(3);
      rd_chk(IDX_STAT_LOW, 32'h04);
      chk_word(sword(kb + 8'h02));
      push(2);
      rd_chk(IDX_STAT_LOW, 32'h03);
      wr(IDX_CTRL_FOUR, 32'h0);
      wr(IDX_CTRL_TWO, 32'h0);
      wr(IDX_EMB_EN, 32'h04);
      wr(IDX_CTRL_FOUR, {29'h0, MODE_STOP_FULL});
      cls <= 32'h0000_5500;
      ts <= 32'h89AB_CDEF;
      idle();
      rd_chk(IDX_STAT_LOW, 32'h0);
      wr(IDX_EMB_EN, 32'h06);
      cls <= 32'h003C_5500;
      idle();
      rd_chk(IDX_STAT_LOW, 32'h01);
      chk_word({32'h89AB_CDEF, 8'h02, 8'h3C, 8'h02});
      wr(IDX_CTRL_FOUR, 32'h0);
      wr(IDX_EMB_EN, 32'h09);
      wr(IDX_CTRL_FOUR, {29'h0, MODE_STOP_FULL});
      fval <= 16'h3C00;
      fid <= 16'h1234;
      repeat (3)
      begin
         @(posedge clk_sys);
         fv <= 1'b1;
         @(posedge clk_sys);
         fv <= 1'b0;
      end
      idle();
      rd_chk(IDX_STAT_LOW, 32'h03);
      chk_word({16'h0, 16'h1234, 16'h3C00, 8'h03});
      give_verdict();
   end
endmodule
`default_nettype wire
